// ---- mif_pkg.sv ----
// constants, types and helpers of the interrupt flag and call logic
// assumes one clock, clk_sys, taken as the oscillator of a 12-period machine cycle
// Contract
// - accept: finish instruction, push pc, record level, block level, load vector
// - return from interrupt restores previous in-service level so program resumes
// - trigger type zero: sampled low pin level is an active request
// - trigger type one: flag set when one sample high, next sample low
// - edge triggered external flag cleared by hardware when call is made
// - pin levels, serial and timer c external flags latched at S5P2
// - timer a and b overflow flags set at S5P2, polled next cycle
// - timer c overflow flag set at S2P2, polled in same cycle
// - accepted request runs a two machine cycle call as next instruction
// - extra delay at most 3 cycles, or 5 after return or enable writes
// - single source latency above 3 and below 9 machine cycles
// - no service while same level routine still in service
// - after return, one program instruction runs before any vectoring
// - high pre-empts low; low never pre-empts low; high never pre-empted
// - serial and timer c flags never cleared by hardware on vectoring
// - blocked flag gone when block lifts is not serviced; polls use fresh samples
`default_nettype none
package mif_pkg;
  // ==========================================================
  // timing
  localparam int OSC_PER_MC = 12;
  localparam int PH_W = 4;
  localparam logic [PH_W-1:0] PH_S2P2 = 4'h3;
  localparam logic [PH_W-1:0] PH_S5P1 = 4'h8;
  localparam logic [PH_W-1:0] PH_S5P2 = 4'h9;
  // ==========================================================
  // register map, byte addresses
  localparam int AW = 8;
  localparam logic [AW-1:0] REG_TRIG = 8'h00;
  localparam logic [AW-1:0] REG_ENABLE = 8'h04;
  localparam logic [AW-1:0] REG_PRIO = 8'h08;
  localparam logic [AW-1:0] REG_FLAGS = 8'h0C;
  localparam logic [AW-1:0] REG_STATUS = 8'h10;
  localparam int EN_GLOBAL = 7;
  // ==========================================================
  // flag bit positions
  localparam int FLG_EXT0 = 0;
  localparam int FLG_TA = 1;
  localparam int FLG_EXT1 = 2;
  localparam int FLG_TB = 3;
  localparam int FLG_RX = 4;
  localparam int FLG_TX = 5;
  localparam int FLG_TCO = 6;
  localparam int FLG_TCE = 7;
  localparam int NSRC = 6;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_SER = 3'h4;
  localparam logic [2:0] SRC_TC = 3'h5;
  // ==========================================================
  // vectors
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  // ==========================================================
  // call sequence
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_CALL1 = 2'b10,
    SEQ_CALL2 = 2'b11
  } mif_seq_t;

  // lowest set index wins: the fixed order within a level
  function automatic logic [2:0] mif_pick(input logic [NSRC-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : mif_pick

  function automatic logic [15:0] mif_vec(input logic [2:0] src);
    return 16'(VEC_BASE + VEC_STEP * {13'h0, src});
  endfunction : mif_vec
endpackage : mif_pkg
`default_nettype wire

// ---- mif_phase_if.sv ----
// phase strobes of the machine cycle, shared by the divider and the flag logic
// assumes all strobes are one clk_sys cycle wide
`default_nettype none
interface mif_phase_if;
  logic s2p2; // phase S2P2
  logic s5p1; // poll point
  logic s5p2; // sampling point
  logic mc_end; // last phase of cycle
  modport drv(output s2p2, output s5p1, output s5p2, output mc_end);
  modport rcv(input s2p2, input s5p1, input s5p2, input mc_end);
endinterface : mif_phase_if
`default_nettype wire

// ---- mif_phase_gen.sv ----
// machine cycle divider: counts oscillator periods, emits phase strobes
// assumes a reset already synchronised to clk_sys
`default_nettype none
module mif_phase_gen #(
  parameter int MC_LEN = mif_pkg::OSC_PER_MC // periods per machine cycle
) (
  input wire logic clk_sys, // oscillator clock
  input wire logic rst_sys_b, // synchronised reset, low active
  mif_phase_if.drv ph // phase strobes
);
  import mif_pkg::*;

  // ==========================================================
  // parameter check
  if (MC_LEN < OSC_PER_MC || MC_LEN > 16) begin : g_bad_len
    $error("mif_phase_gen: MC_LEN out of range");
  end

  localparam logic [PH_W-1:0] MC_LAST = PH_W'(MC_LEN - 1);

  typedef struct packed {
    logic [PH_W-1:0] cnt;
    logic s2p2;
    logic s5p1;
    logic s5p2;
    logic mc_end;
  } mif_ph_st_t;

  mif_ph_st_t st_ff;
  mif_ph_st_t nxt_st;

  // ==========================================================
  // strobes registered so they mark the cycle the count shows
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cnt = (st_ff.cnt == MC_LAST) ? '0 : PH_W'(st_ff.cnt + 1'b1);
    nxt_st.s2p2 = (nxt_st.cnt == PH_S2P2);
    nxt_st.s5p1 = (nxt_st.cnt == PH_S5P1);
    nxt_st.s5p2 = (nxt_st.cnt == PH_S5P2);
    nxt_st.mc_end = (nxt_st.cnt == MC_LAST);
  end

  always_ff @(posedge clk_sys or negedge rst_sys_b) begin
    if (!rst_sys_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ph.s2p2 = st_ff.s2p2;
  assign ph.s5p1 = st_ff.s5p1;
  assign ph.s5p2 = st_ff.s5p2;
  assign ph.mc_end = st_ff.mc_end;
endmodule : mif_phase_gen
`default_nettype wire

// ---- mif_irq_top.sv ----
// interrupt flag sampling, polling and hardware call sequencing, APB registers
// assumes the core reports its instruction cycle on same-clock level inputs
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`default_nettype none
module mif_irq_top #(
  parameter int MC_LEN = mif_pkg::OSC_PER_MC // periods per machine cycle
) (
  input wire logic clk_sys, // 100 MHz clock
  input wire logic rst_b, // async reset, low active
  input wire logic [mif_pkg::AW-1:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic ext_request_pin_a, // external request pin 0
  input wire logic ext_request_pin_b, // external request pin 1
  input wire logic timer_a_ovf_evt, // timer a overflow pulse
  input wire logic timer_b_ovf_evt, // timer b overflow pulse
  input wire logic timer_c_ovf_evt, // timer c overflow pulse
  input wire logic timer_c_ext_evt, // timer c external pulse
  input wire logic serial_tx_evt, // serial tx done pulse
  input wire logic serial_rx_evt, // serial rx done pulse
  input wire logic instr_final_cycle, // core in last instr cycle
  input wire logic instr_is_return_from_interrupt, // instr is return from int
  input wire logic instr_ie_ip_access, // instr touches enable/prio
  input wire logic return_from_interrupt_done, // return executed, pulse
  output logic call_req, // hardware call in progress
  output logic push_pc, // push pc now, pulse
  output logic load_pc, // load vector now, pulse
  output logic [15:0] vector_addr, // vector of call
  output logic in_service_hi, // high level routine active
  output logic in_service_lo // low level routine active
);
  import mif_pkg::*;

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_ff;
  logic rst_sys_b;

  // two stages so release never lands near a clock edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sys_b = rst_sync_ff[1];

  // ==========================================================
  // phase divider
  mif_phase_if ph_if ();

  mif_phase_gen #(
    .MC_LEN(MC_LEN)
  ) u_phase (
    .clk_sys(clk_sys),
    .rst_sys_b(rst_sys_b),
    .ph(ph_if.drv)
  );

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] trig;
    logic [NSRC-1:0] en;
    logic glob;
    logic [NSRC-1:0] prio;
    logic [7:0] flag;
    logic [5:0] pend;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] pin;
    logic [1:0] prev;
    logic [7:0] smp;
    logic svc_hi;
    logic svc_lo;
    logic blk_wr;
    mif_seq_t seq;
    logic [2:0] src;
    logic [15:0] vec;
    logic call;
    logic push;
    logic load;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mif_st_t;

  mif_st_t st_ff;
  mif_st_t nxt_st;
  logic acc;
  logic accept;
  logic blocked;
  logic [NSRC-1:0] reqv;
  logic [NSRC-1:0] cand_hi;
  logic [NSRC-1:0] cand_lo;

  // ==========================================================
  // combinational next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.push = 1'b0;
    nxt_st.load = 1'b0;
    // three-stage pin sync, a change counts once stages two and three agree
    nxt_st.s1 = {ext_request_pin_b, ext_request_pin_a};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < 2; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.pin[i] = st_ff.s3[i];
      end
    end

    // apb slave, one wait state
    acc = psel && penable && !st_ff.pready;
    nxt_st.pready = acc;
    nxt_st.pslverr = 1'b0;
    if (acc) begin
      nxt_st.prdata = 32'h0;
      case (paddr)
        REG_TRIG: begin
          if (pwrite) nxt_st.trig = pwdata[1:0];
          else nxt_st.prdata = {30'h0, st_ff.trig};
        end
        REG_ENABLE: begin
          if (pwrite) begin
            nxt_st.en = pwdata[NSRC-1:0];
            nxt_st.glob = pwdata[EN_GLOBAL];
            nxt_st.blk_wr = 1'b1;
          end else begin
            nxt_st.prdata = {24'h0, st_ff.glob, 1'b0, st_ff.en};
          end
        end
        REG_PRIO: begin
          if (pwrite) begin
            nxt_st.prio = pwdata[NSRC-1:0];
            nxt_st.blk_wr = 1'b1;
          end else begin
            nxt_st.prdata = {26'h0, st_ff.prio};
          end
        end
        REG_FLAGS: begin
          // software sets or clears flags as hardware would
          if (pwrite) nxt_st.flag = pwdata[7:0];
          else nxt_st.prdata = {24'h0, st_ff.flag};
        end
        REG_STATUS: begin
          if (pwrite) nxt_st.pslverr = 1'b1;
          else nxt_st.prdata = {24'h0, st_ff.call, st_ff.seq, st_ff.src,
                                st_ff.svc_hi, st_ff.svc_lo};
        end
        default: begin
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end

    // poll: samples from the previous S5P2, timer c overflow live
    reqv = '0;
    reqv[SRC_EXT0] = st_ff.smp[FLG_EXT0];
    reqv[1] = st_ff.smp[FLG_TA];
    reqv[SRC_EXT1] = st_ff.smp[FLG_EXT1];
    reqv[3] = st_ff.smp[FLG_TB];
    reqv[SRC_SER] = st_ff.smp[FLG_RX] | st_ff.smp[FLG_TX];
    reqv[SRC_TC] = st_ff.flag[FLG_TCO] | st_ff.smp[FLG_TCE];
    cand_hi = reqv & st_ff.en & st_ff.prio & {NSRC{st_ff.glob}};
    cand_lo = reqv & st_ff.en & ~st_ff.prio & {NSRC{st_ff.glob}};
    // final cycle only, never during return or enable access
    blocked = !instr_final_cycle || instr_is_return_from_interrupt || instr_ie_ip_access
              || st_ff.blk_wr || (st_ff.seq != SEQ_IDLE);
    accept = 1'b0;
    if (ph_if.s5p1) begin
      nxt_st.blk_wr = 1'b0;
      if (!blocked && cand_hi != '0 && !st_ff.svc_hi) begin
        accept = 1'b1;
        nxt_st.src = mif_pick(cand_hi);
        nxt_st.svc_hi = 1'b1;
      end else if (!blocked && cand_lo != '0 && !st_ff.svc_hi && !st_ff.svc_lo) begin
        accept = 1'b1;
        nxt_st.src = mif_pick(cand_lo);
        nxt_st.svc_lo = 1'b1;
      end
      // a write landing on the poll cycle still blocks the next one
      if (acc && pwrite && (paddr == REG_ENABLE || paddr == REG_PRIO)) begin
        nxt_st.blk_wr = 1'b1;
      end
    end
    if (accept) begin
      nxt_st.seq = SEQ_WAIT;
      nxt_st.vec = mif_vec(nxt_st.src);
      // edge external and timer a/b flags cleared; paired flags stay for software
      if (nxt_st.src == SRC_EXT0 && st_ff.trig[0]) nxt_st.flag[FLG_EXT0] = 1'b0;
      if (nxt_st.src == SRC_EXT1 && st_ff.trig[1]) nxt_st.flag[FLG_EXT1] = 1'b0;
      if (nxt_st.src == 3'h1) nxt_st.flag[FLG_TA] = 1'b0;
      if (nxt_st.src == 3'h3) nxt_st.flag[FLG_TB] = 1'b0;
    end

    // return: drop the most recent level, uncovering the older one
    if (return_from_interrupt_done) begin
      // next poll blocked too, so one program instruction runs first
      nxt_st.blk_wr = 1'b1;
      if (st_ff.svc_hi) nxt_st.svc_hi = 1'b0;
      else nxt_st.svc_lo = 1'b0;
    end

    // flag setting at the machine cycle phases, set wins over clear
    if (ph_if.s5p2) begin
      for (int i = 0; i < 2; i++) begin
        if (!st_ff.trig[i]) begin
          nxt_st.flag[2*i] = !st_ff.pin[i];
        end else if (st_ff.prev[i] && !st_ff.pin[i]) begin
          nxt_st.flag[2*i] = 1'b1;
        end
      end
      nxt_st.prev = st_ff.pin;
      if (st_ff.pend[0]) nxt_st.flag[FLG_TA] = 1'b1;
      if (st_ff.pend[1]) nxt_st.flag[FLG_TB] = 1'b1;
      if (st_ff.pend[2]) nxt_st.flag[FLG_RX] = 1'b1;
      if (st_ff.pend[3]) nxt_st.flag[FLG_TX] = 1'b1;
      if (st_ff.pend[5]) nxt_st.flag[FLG_TCE] = 1'b1;
      nxt_st.pend[3:0] = 4'h0;
      nxt_st.pend[5] = 1'b0;
      nxt_st.smp = nxt_st.flag;
    end
    if (ph_if.s2p2) begin
      if (st_ff.pend[4]) nxt_st.flag[FLG_TCO] = 1'b1;
      nxt_st.pend[4] = 1'b0;
    end
    // events arriving on the transfer cycle are kept for the next one
    nxt_st.pend = nxt_st.pend | {timer_c_ext_evt, timer_c_ovf_evt, serial_tx_evt,
                                 serial_rx_evt, timer_b_ovf_evt, timer_a_ovf_evt};

    // call of two machine cycles, starting at the next cycle boundary
    if (ph_if.mc_end) begin
      case (st_ff.seq)
        SEQ_IDLE: begin
          nxt_st.seq = SEQ_IDLE;
        end
        SEQ_WAIT: begin
          nxt_st.seq = SEQ_CALL1;
          nxt_st.call = 1'b1;
          nxt_st.push = 1'b1;
        end
        SEQ_CALL1: begin
          nxt_st.seq = SEQ_CALL2;
        end
        SEQ_CALL2: begin
          nxt_st.seq = SEQ_IDLE;
          nxt_st.call = 1'b0;
          nxt_st.load = 1'b1;
        end
        default: begin
          nxt_st.seq = SEQ_IDLE;
        end
      endcase
    end
  end

  localparam mif_st_t ST_RST = '0;

  always_ff @(posedge clk_sys or negedge rst_sys_b) begin
    if (!rst_sys_b) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign call_req = st_ff.call;
  assign push_pc = st_ff.push;
  assign load_pc = st_ff.load;
  assign vector_addr = st_ff.vec;
  assign in_service_hi = st_ff.svc_hi;
  assign in_service_lo = st_ff.svc_lo;

  // ==========================================================
  // assertions
  property p_edge_set;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      ph_if.s5p2 && st_ff.trig[0] && st_ff.prev[0] && !st_ff.pin[0]
      |=> st_ff.flag[FLG_EXT0];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  property p_level_follow;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      ph_if.s5p2 && !st_ff.trig[1] |=> st_ff.flag[FLG_EXT1] == !$past(st_ff.pin[1]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag wrong");

  property p_call_len;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      $rose(st_ff.call) |-> st_ff.push ##23 st_ff.call ##1 (!st_ff.call && st_ff.load);
  endproperty
  a_call_len: assert property (p_call_len) else $error("call not two cycles");

  property p_edge_clear;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      accept && nxt_st.src == SRC_EXT0 && st_ff.trig[0] |=> !st_ff.flag[FLG_EXT0];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept");

  property p_ser_kept;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      accept && nxt_st.src == SRC_SER && !acc && !ph_if.s5p2
      |=> st_ff.flag[FLG_RX] == $past(st_ff.flag[FLG_RX]);
  endproperty
  a_ser_kept: assert property (p_ser_kept) else $error("serial flag cleared");

  property p_same_level;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      accept |-> !st_ff.svc_hi && (!st_ff.svc_lo || cand_hi != '0);
  endproperty
  a_same_level: assert property (p_same_level) else $error("same level pre-empted");

  property p_return_from_interrupt_block;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      ph_if.s5p1 && instr_is_return_from_interrupt |=> st_ff.seq == $past(st_ff.seq);
  endproperty
  a_return_from_interrupt_block: assert property (p_return_from_interrupt_block) else $error("vectored on return");

  property p_tco_set;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      ph_if.s2p2 && st_ff.pend[4] |=> st_ff.flag[FLG_TCO];
  endproperty
  a_tco_set: assert property (p_tco_set) else $error("timer c flag late");

  property p_latency;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      accept |-> ##[1:12] st_ff.push ##24 (!st_ff.call && !st_ff.push);
  endproperty
  a_latency: assert property (p_latency) else $error("call start late");

  property p_vec;
    @(posedge clk_sys) disable iff (!rst_sys_b)
      st_ff.load |-> st_ff.vec == {10'h000, st_ff.src, 3'h3};
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");

  c_hi_over_lo: cover property (@(posedge clk_sys) disable iff (!rst_sys_b)
    st_ff.svc_lo && st_ff.svc_hi);
  c_call_done: cover property (@(posedge clk_sys) disable iff (!rst_sys_b) st_ff.load);
  c_return_from_interrupt: cover property (@(posedge clk_sys) disable iff (!rst_sys_b)
    return_from_interrupt_done && st_ff.svc_lo);
endmodule : mif_irq_top
`default_nettype wire

// ---- mif_core_model.sv ----
// behavioural model of the core sequencer that faces the flag logic
// assumes one clock shared with the flag logic and a one-clk ret_cmd pulse
`default_nettype none
module mif_core_model (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, low active
  input wire logic ret_cmd, // run one return instruction
  input wire logic mul_cmd, // run one four machine cycle instruction
  output logic instr_final_cycle, // last instr cycle
  output logic instr_is_return_from_interrupt, // return in progress
  output logic instr_ie_ip_access, // enable/prio access
  output logic return_from_interrupt_done // return executed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_ff;
  logic [5:0] mcnt_ff;
  // ==========================================================
  // return instruction: one machine cycle long, done pulse in its last clk
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 5'h00;
    end else if (ret_cmd) begin
      cnt_ff <= 5'h0C;
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
    end
  end
  // long instruction: only its last machine cycle is a final cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mcnt_ff <= 6'h00;
    end else if (mul_cmd) begin
      mcnt_ff <= 6'h30;
    end else if (mcnt_ff != 6'h00) begin
      mcnt_ff <= mcnt_ff - 6'h01;
    end
  end
  assign instr_final_cycle = (mcnt_ff <= 6'h0C);
  assign instr_is_return_from_interrupt = (cnt_ff != 5'h00);
  assign instr_ie_ip_access = 1'b0;
  assign return_from_interrupt_done = (cnt_ff == 5'h01);
endmodule : mif_core_model
`default_nettype wire

// ---- mcu_interrupt_flag_logic_tb.sv ----
// self-checking bench of the interrupt flag and call logic
// assumes the design answers apb with one wait state, as handed over
`default_nettype none
module mcu_interrupt_flag_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mif_pkg::*;
  typedef struct {
    logic [5:0] ev;
    logic [15:0] vec;
    logic [31:0] en;
    logic [31:0] flg;
  } mif_row_t;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e;
  logic pin_a = 1'b1, pin_b = 1'b1, ret_cmd = 1'b0, mul_cmd = 1'b0;
  logic [5:0] ev = 6'h00;
  logic fin, return_from_interrupt, ieip, rdone, call_req, push_pc, load_pc, svc_hi, svc_lo;
  logic [15:0] vec;
  int fails = 0, n_checks = 0, cyc = 0, n_push = 0, n;
  // ordinary cases: one event source each, expected vector and flags after call
  mif_row_t rows [6] = '{
    '{6'h01, 16'h000B, 32'h82, 32'h00}, '{6'h02, 16'h001B, 32'h88, 32'h00},
    '{6'h04, 16'h002B, 32'hA0, 32'h40}, '{6'h08, 16'h002B, 32'hA0, 32'h80},
    '{6'h10, 16'h0023, 32'h90, 32'h20}, '{6'h20, 16'h0023, 32'h90, 32'h10}};
  mif_irq_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_request_pin_a(pin_a),
    .ext_request_pin_b(pin_b), .timer_a_ovf_evt(ev[0]), .timer_b_ovf_evt(ev[1]),
    .timer_c_ovf_evt(ev[2]), .timer_c_ext_evt(ev[3]), .serial_tx_evt(ev[4]),
    .serial_rx_evt(ev[5]), .instr_final_cycle(fin), .instr_is_return_from_interrupt(return_from_interrupt),
    .instr_ie_ip_access(ieip), .return_from_interrupt_done(rdone), .call_req(call_req),
    .push_pc(push_pc), .load_pc(load_pc), .vector_addr(vec),
    .in_service_hi(svc_hi), .in_service_lo(svc_lo));
  mif_core_model core (.clk_sys(clk_sys), .rst_b(rst_b), .ret_cmd(ret_cmd), .mul_cmd(mul_cmd),
    .instr_final_cycle(fin), .instr_is_return_from_interrupt(return_from_interrupt), .instr_ie_ip_access(ieip),
    .return_from_interrupt_done(rdone));
  // ==========================================================
  // clock, hang guard and call counter
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (push_pc === 1'b1) n_push++;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // wait for the call to start; latency counted in clk
  task automatic wait_call();
    n = 0;
    while (call_req !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_call
  task automatic wait_load();
    while (load_pc !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_load
  task automatic ret();
    @(posedge clk_sys);
    ret_cmd <= 1'b1;
    @(posedge clk_sys);
    ret_cmd <= 1'b0;
    repeat (30) @(posedge clk_sys);
  endtask : ret
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk_sys);
    foreach (rows[i]) begin
      apb(1'b1, REG_ENABLE, rows[i].en);
      ev <= rows[i].ev;
      @(posedge clk_sys);
      ev <= 6'h00;
      wait_call();
      chk({16'h0, vec}, {16'h0, rows[i].vec});
      chk({31'h0, svc_lo}, 32'h1);
      n = 0;
      wait_load();
      chk(n, 24);
      apb(1'b0, REG_FLAGS, 32'h0);
      chk(q, rows[i].flg);
      apb(1'b1, REG_FLAGS, 32'h0);
      ret();
      chk({31'h0, svc_lo}, 32'h0);
    end
    // level request: latency, then same level blocked, high pre-empts low
    apb(1'b1, REG_ENABLE, 32'h83);
    pin_a <= 1'b0;
    n = 0;
    wait_call();
    wait_load();
    chk((n > 36 && n < 108), 32'h1);
    chk({16'h0, vec}, 32'h0003);
    pin_a <= 1'b1;
    ev <= 6'h01;
    @(posedge clk_sys);
    ev <= 6'h00;
    n = n_push;
    repeat (60) @(posedge clk_sys);
    chk(n_push, n);
    apb(1'b1, REG_PRIO, 32'h02);
    wait_call();
    chk({16'h0, vec}, 32'h000B);
    chk({30'h0, svc_hi, svc_lo}, 32'h3);
    wait_load();
    ret();
    chk({30'h0, svc_hi, svc_lo}, 32'h1);
    ret();
    apb(1'b1, REG_PRIO, 32'h00);
    // edge request on the second pin, flag cleared by the call
    apb(1'b1, REG_TRIG, 32'h2);
    apb(1'b1, REG_ENABLE, 32'h84);
    repeat (24) @(posedge clk_sys);
    pin_b <= 1'b0;
    wait_call();
    chk({16'h0, vec}, 32'h0013);
    wait_load();
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(q & 32'h4, 32'h0);
    pin_b <= 1'b1;
    ret();
    // four cycle instruction: timer a request waits for its final cycle
    apb(1'b1, REG_ENABLE, 32'h82);
    mul_cmd <= 1'b1;
    ev <= 6'h01;
    @(posedge clk_sys);
    mul_cmd <= 1'b0;
    ev <= 6'h00;
    n = n_push;
    repeat (30) @(posedge clk_sys);
    chk(n_push, n);
    wait_call();
    chk((n < 80), 32'h1);
    chk({16'h0, vec}, 32'h000B);
    wait_load();
    ret();
    // unmapped address refused, then reset in mid-run clears the block
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({29'h0, call_req, svc_hi, svc_lo}, 32'h0);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
    apb(1'b0, REG_ENABLE, 32'h0);
    chk(q, 32'h0);
    finish_test();
  end
endmodule : mcu_interrupt_flag_logic_tb
`default_nettype wire
